// ==== logic/mps_pkg.sv ====
// mps_pkg: constants shared by the program sequencer core, its alu and its return stack.
// assumes a single 20 MHz clock; all encodings here are internal to this core.
package mps_pkg;
	// ==========================================================
	// sizes
	localparam int PC_W = 11;
	localparam int WORD_W = 16;
	localparam int DATA_W = 8;
	localparam int PMEM_DEPTH = 2048;
	localparam int STACK_DEPTH = 4;
	localparam int SP_W = 3;
	localparam int CLK_HZ = 20000000;
	localparam int PAGE_SIZE = 256;

	// ==========================================================
	// vectors
	localparam logic [10:0] RESET_VECTOR = 11'h000;
	localparam logic [10:0] INT_VECTOR = 11'h004;

	// ==========================================================
	// instruction phases, one clk each
	typedef enum logic [1:0] {PH_FETCH, PH_EXEC2, PH_EXEC3, PH_EXEC4} mps_phase_e;

	// ==========================================================
	// opcode field [15:12]
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_LDI = 4'h1;
	localparam logic [3:0] OP_ADD = 4'h2;
	localparam logic [3:0] OP_SUB = 4'h3;
	localparam logic [3:0] OP_AND = 4'h4;
	localparam logic [3:0] OP_OR = 4'h5;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_UNARY = 4'h7;
	localparam logic [3:0] OP_JUMP = 4'h8;
	localparam logic [3:0] OP_CALL = 4'h9;
	localparam logic [3:0] OP_RET = 4'hA;
	localparam logic [3:0] OP_SKIP = 4'hB;
	localparam logic [3:0] OP_MOVPCL = 4'hC;
	localparam logic [3:0] OP_TBL = 4'hD;
	// sub field [2:0] of unary ops
	localparam logic [2:0] UN_INC = 3'h0;
	localparam logic [2:0] UN_DEC = 3'h1;
	localparam logic [2:0] UN_RL = 3'h2;
	localparam logic [2:0] UN_RR = 3'h3;
	localparam logic [2:0] UN_RLC = 3'h4;
	localparam logic [2:0] UN_RRC = 3'h5;
	localparam logic [2:0] UN_CPL = 3'h6;
	// sub field of table ops
	localparam logic [2:0] TB_SETLO = 3'h0;
	localparam logic [2:0] TB_SETHI = 3'h1;
	localparam logic [2:0] TB_READ = 3'h2;
	localparam int OP_LSB = 12;
	localparam int INTERRUPT_RETURN_OP_BIT = 0;
	localparam int SKIP_NZ_BIT = 0;

	// ==========================================================
	// register map, byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PCL = 8'h08;
	localparam logic [7:0] REG_PM_ADDR = 8'h0C;
	localparam logic [7:0] REG_PM_DATA = 8'h10;
	localparam logic [7:0] REG_ACC = 8'h14;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_IEN = 1;
	localparam int ST_PC_LSB = 0;
	localparam int ST_C = 16;
	localparam int ST_Z = 17;
	localparam int ST_IRQF = 18;
	localparam int ST_FULL = 19;
	localparam int ST_TBL = 20;
	localparam int ACC_TBLH_LSB = 8;
endpackage : mps_pkg

// ==== logic/mps_alu.sv ====
// mps_alu: 8-bit combinational alu with carry and zero.
// assumes operands come straight from the accumulator and the immediate field.
`timescale 1ns/100ps
`default_nettype none
module mps_alu (
	input wire logic [3:0] op,
	input wire logic [2:0] sub,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic c_in,
	output logic [7:0] res,
	output logic c_out,
	output logic z
);
	import mps_pkg::*;
	logic [8:0] wide;
	always_comb begin
		res = a;
		c_out = c_in;
		wide = 9'h000;
		case (op)
			OP_LDI: res = b;
			OP_ADD: begin
				wide = {1'b0, a} + {1'b0, b};
				res = wide[7:0];
				c_out = wide[8];
			end
			OP_SUB: begin
				// carry set means no borrow
				wide = {1'b0, a} - {1'b0, b};
				res = wide[7:0];
				c_out = ~wide[8];
			end
			OP_AND: res = a & b;
			OP_OR: res = a | b;
			OP_XOR: res = a ^ b;
			OP_UNARY: begin
				case (sub)
					UN_INC: res = a + 8'h01;
					UN_DEC: res = a - 8'h01;
					UN_RL: res = {a[6:0], a[7]};
					UN_RR: res = {a[0], a[7:1]};
					UN_RLC: begin
						res = {a[6:0], c_in};
						c_out = a[7];
					end
					UN_RRC: begin
						res = {c_in, a[7:1]};
						c_out = a[0];
					end
					UN_CPL: res = ~a;
					default: res = a;
				endcase
			end
			default: res = a;
		endcase
		z = (res == 8'h00);
	end
endmodule : mps_alu
`default_nettype wire

// ==== logic/mps_stack.sv ====
// mps_stack: return-address stack, newest entry at level 0.
// assumes push and pop are never requested in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module mps_stack (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [10:0] push_pc,
	output logic [10:0] top_pc,
	output logic full
);
	import mps_pkg::*;
	logic [10:0] lvl_q [STACK_DEPTH];
	logic [SP_W-1:0] sp_q;
	localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

	// pointer starts at top of stack after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_q <= '0; // [RULE13]
		end else if (push && sp_q != SP_FULL) begin
			sp_q <= sp_q + SP_W'(1); // [RULE22]
		end else if (pop && sp_q != '0) begin
			sp_q <= sp_q - SP_W'(1);
		end
	end

	// shifting storage: a push when full drops the oldest entry off the end
	genvar i;
	generate
		for (i = 0; i < STACK_DEPTH; i++) begin : g_lvl
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					lvl_q[i] <= RESET_VECTOR;
				end else if (push) begin
					lvl_q[i] <= (i == 0) ? push_pc : lvl_q[(i == 0) ? 0 : i-1]; // [RULE15]
				end else if (pop) begin
					lvl_q[i] <= (i == STACK_DEPTH-1) ? lvl_q[i] : lvl_q[(i == STACK_DEPTH-1) ? i : i+1]; // [RULE12]
				end
			end
		end
	endgenerate

	assign top_pc = lvl_q[0];
	assign full = (sp_q == SP_FULL);
endmodule : mps_stack
`default_nettype wire

// ==== logic/mps_core.sv ====
// mps_core: instruction sequencer of a small 8-bit risc core with its program memory.
// assumes an avalon-mm master on the register port and an asynchronous interrupt pin.
`timescale 1ns/100ps
`default_nettype none
// Contract
// (RULE1) each instruction cycle is four non-overlapping phases of the system clock
// (RULE2) pc advances and the next instruction is fetched in the fetch phase
// (RULE3) decode and execute happen in the three execute phases
// (RULE4) fetch of next instruction overlaps execution of the current one
// (RULE5) pc-changing instructions take one extra cycle: address, then branch
// (RULE6) pc increments by one except on non-consecutive transfers
// (RULE7) a taken skip discards the prefetched instruction for a dummy cycle
// (RULE8) pc is 11 bits; only the low byte is program accessible
// (RULE9) writing pc low byte jumps within current 256-word page, with dummy cycle
// (RULE10) jumps, calls, interrupts and reset load the destination into pc
// (RULE11) stack holds only pc values and is invisible to software
// (RULE12) call or interrupt acknowledge pushes pc; return instructions pop it
// (RULE13) after reset the stack pointer marks the top of stack
// (RULE14) full stack holds an interrupt pending until a return frees a level
// (RULE15) a call on a full stack still runs and loses the oldest entry
// (RULE16) arithmetic, logic, rotate, inc, dec and decisions use an 8-bit alu; the skip decision tests acc_q directly, outside mps_alu
// (RULE17) alu results go to the accumulator and update carry and zero status
// (RULE18) program memory is 2K words of 16 bits addressed by pc
// (RULE19) execution starts at address zero after reset
// (RULE20) table address is formed from the low and high table pointers
// (RULE21) each table read takes two instruction cycles
// (RULE22) the return stack has four levels tracked by the stack pointer
module mps_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic irq_req,
	output logic irq_ack,
	output logic [1:0] instruction_phase
);
	import mps_pkg::*;

	// ==========================================================
	// register hit decode, shared by read and write paths
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// ==========================================================
	// state
	mps_phase_e phase_q;
	logic run_q;
	logic ien_q;
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] pc_d;
	logic [WORD_W-1:0] fetch_q;
	logic [PC_W-1:0] fetch_pc_q;
	logic [WORD_W-1:0] ir_q;
	logic [PC_W-1:0] ir_pc_q;
	logic ir_ok_q;
	logic tbl_q;
	logic [DATA_W-1:0] acc_q;
	logic [DATA_W-1:0] tblh_q;
	logic [DATA_W-1:0] tblp_q;
	logic [2:0] tbhp_q;
	logic c_q;
	logic z_q;
	logic irqf_q;
	logic [2:0] irq_sync_q;
	logic irq_ack_q;
	logic [PC_W-1:0] pm_addr_q;
	logic [WORD_W-1:0] pmem [PMEM_DEPTH];
	logic wait_q;
	logic [31:0] rdata_q;

	// ==========================================================
	// phase sequencing
	wire fetch_en = run_q && phase_q == PH_FETCH && !tbl_q;
	wire exec = run_q && phase_q == PH_EXEC4;

	// phase counter divides clk by four; a halt lets the cycle run out so a restart opens on fetch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PH_FETCH;
		end else if (run_q || phase_q != PH_FETCH) begin
			case (phase_q) // [RULE1]
				PH_FETCH: phase_q <= PH_EXEC2;
				PH_EXEC2: phase_q <= PH_EXEC3;
				PH_EXEC3: phase_q <= PH_EXEC4;
				PH_EXEC4: phase_q <= PH_FETCH;
				default: phase_q <= PH_FETCH;
			endcase
		end
	end

	// ==========================================================
	// decode of the instruction in execution
	wire [3:0] op = ir_q[15:OP_LSB];
	wire [2:0] sub = ir_q[2:0];
	wire [7:0] imm = ir_q[7:0];
	wire [PC_W-1:0] target = ir_q[PC_W-1:0];
	wire is_alu = (op >= OP_LDI) && (op <= OP_UNARY);
	wire skip_cond = ir_q[SKIP_NZ_BIT] ? (acc_q != 8'h00) : (acc_q == 8'h00);
	wire stk_full;
	wire [PC_W-1:0] stk_top;

	// an interrupt waits while the stack is full; a return clears the way
	wire do_tbl = exec && tbl_q; // [RULE21]
	wire do_irq = exec && !tbl_q && ir_ok_q && irqf_q && ien_q && !stk_full; // [RULE14]
	wire do_ins = exec && !tbl_q && !do_irq && ir_ok_q; // [RULE3]
	wire do_jump = do_ins && (op == OP_JUMP || op == OP_CALL);
	wire do_call = do_ins && op == OP_CALL;
	wire do_ret = do_ins && op == OP_RET;
	wire do_interrupt_return_op = do_ret && ir_q[INTERRUPT_RETURN_OP_BIT];
	wire do_pcl = do_ins && op == OP_MOVPCL;
	wire do_skip = do_ins && op == OP_SKIP && skip_cond;
	wire do_tset_lo = do_ins && op == OP_TBL && sub == TB_SETLO;
	wire do_tset_hi = do_ins && op == OP_TBL && sub == TB_SETHI;
	wire do_tstart = do_ins && op == OP_TBL && sub == TB_READ;
	wire do_alu = do_ins && is_alu; // [RULE16]
	// any of these discards the prefetched word and runs a dummy cycle
	wire flush = do_irq || do_jump || do_ret || do_pcl || do_skip; // [RULE5] [RULE7]

	// ==========================================================
	// bus decode
	wire bus_wr = avs_write && !wait_q;
	wire bus_rd_take = avs_read && wait_q;
	wire wr_ctrl = bus_wr && reg_hit(avs_address, REG_CTRL);
	// debug writes to pc and memory only while halted, so the core never races them
	wire wr_pcl = bus_wr && reg_hit(avs_address, REG_PCL) && !run_q;
	wire wr_pma = bus_wr && reg_hit(avs_address, REG_PM_ADDR);
	wire wr_pmd = bus_wr && reg_hit(avs_address, REG_PM_DATA) && !run_q;

	// ==========================================================
	// program counter
	assign pc_d = fetch_en ? pc_q + 11'h001 : // [RULE2] [RULE6]
		do_irq ? INT_VECTOR : // [RULE10]
		do_jump ? target :
		do_ret ? stk_top : // [RULE12]
		do_pcl ? {pc_q[PC_W-1:DATA_W], acc_q} : // [RULE9]
		wr_pcl ? {pc_q[PC_W-1:DATA_W], avs_writedata[DATA_W-1:0]} : // [RULE8]
		pc_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= RESET_VECTOR; // [RULE19]
		end else begin
			pc_q <= pc_d;
		end
	end

	// ==========================================================
	// fetch stage; a pending table read holds the prefetched word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_q <= '0;
			fetch_pc_q <= RESET_VECTOR;
		end else if (fetch_en) begin
			fetch_q <= pmem[pc_q]; // [RULE18] [RULE4]
			fetch_pc_q <= pc_q;
		end
	end

	// ==========================================================
	// execute stage register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_q <= '0;
			ir_pc_q <= RESET_VECTOR;
			ir_ok_q <= 1'b0;
		end else if (exec && !do_tstart) begin
			ir_q <= fetch_q; // [RULE4]
			ir_pc_q <= fetch_pc_q;
			ir_ok_q <= !flush;
		end else if (wr_pcl) begin
			ir_ok_q <= 1'b0;
		end
	end

	// two-cycle table read: start cycle, then data cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tbl_q <= 1'b0;
		end else if (do_tstart) begin
			tbl_q <= 1'b1; // [RULE21]
		end else if (do_tbl) begin
			tbl_q <= 1'b0;
		end
	end

	// ==========================================================
	// table pointers and alu datapath
	wire [WORD_W-1:0] tword = pmem[{tbhp_q, tblp_q}]; // [RULE20]
	wire [DATA_W-1:0] alu_res;
	wire alu_c;
	wire alu_z;

	mps_alu u_alu (
		.op(op),
		.sub(sub),
		.a(acc_q),
		.b(imm),
		.c_in(c_q),
		.res(alu_res),
		.c_out(alu_c),
		.z(alu_z)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tblp_q <= '0;
			tbhp_q <= '0;
		end else begin
			if (do_tset_lo) tblp_q <= acc_q;
			if (do_tset_hi) tbhp_q <= acc_q[2:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
			c_q <= 1'b0;
			z_q <= 1'b0;
			tblh_q <= '0;
		end else if (do_alu) begin
			acc_q <= alu_res; // [RULE17]
			c_q <= alu_c;
			z_q <= alu_z;
		end else if (do_tbl) begin
			acc_q <= tword[DATA_W-1:0];
			tblh_q <= tword[WORD_W-1:DATA_W];
		end
	end

	// ==========================================================
	// return stack, reachable only through call, return and interrupt
	mps_stack u_stack (
		.clk(clk),
		.rst_n(rst_n),
		.push(do_call || do_irq), // [RULE12] [RULE11]
		.pop(do_ret),
		.push_pc(do_irq ? ir_pc_q : fetch_pc_q),
		.top_pc(stk_top),
		.full(stk_full)
	);

	// ==========================================================
	// interrupt request: pin synchronised, rising edge sets the flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_sync_q <= '0;
		end else begin
			irq_sync_q <= {irq_sync_q[1:0], irq_req};
		end
	end

	wire irq_rise = irq_sync_q[1] && !irq_sync_q[2];

	// set wins over the acknowledge clear so no edge is lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqf_q <= 1'b0;
			irq_ack_q <= 1'b0;
		end else begin
			irqf_q <= irq_rise || (irqf_q && !do_irq); // [RULE14]
			irq_ack_q <= do_irq;
		end
	end

	// ==========================================================
	// control: run and global interrupt enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			ien_q <= 1'b0;
		end else begin
			if (wr_ctrl) run_q <= avs_writedata[CTRL_RUN];
			if (do_irq) begin
				ien_q <= 1'b0;
			end else if (do_interrupt_return_op) begin
				ien_q <= 1'b1;
			end else if (wr_ctrl) begin
				ien_q <= avs_writedata[CTRL_IEN];
			end
		end
	end

	// ==========================================================
	// program memory loader
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pm_addr_q <= '0;
		end else if (wr_pma) begin
			pm_addr_q <= avs_writedata[PC_W-1:0];
		end else if (wr_pmd || (bus_rd_take && reg_hit(avs_address, REG_PM_DATA))) begin
			pm_addr_q <= pm_addr_q + 11'h001;
		end
	end

	// no reset on the array: contents persist and only software loads them
	always_ff @(posedge clk) begin
		if (wr_pmd) pmem[pm_addr_q] <= avs_writedata[WORD_W-1:0];
	end

	// ==========================================================
	// avalon slave: every access answers with one wait cycle
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		if (reg_hit(avs_address, REG_CTRL)) begin
			rd_val[CTRL_RUN] = run_q;
			rd_val[CTRL_IEN] = ien_q;
		end else if (reg_hit(avs_address, REG_STATUS)) begin
			rd_val[ST_PC_LSB +: PC_W] = pc_q;
			rd_val[ST_C] = c_q;
			rd_val[ST_Z] = z_q;
			rd_val[ST_IRQF] = irqf_q;
			rd_val[ST_FULL] = stk_full;
			rd_val[ST_TBL] = tbl_q;
		end else if (reg_hit(avs_address, REG_PCL)) begin
			rd_val[DATA_W-1:0] = pc_q[DATA_W-1:0];
		end else if (reg_hit(avs_address, REG_PM_ADDR)) begin
			rd_val[PC_W-1:0] = pm_addr_q;
		end else if (reg_hit(avs_address, REG_PM_DATA)) begin
			rd_val[WORD_W-1:0] = pmem[pm_addr_q];
		end else if (reg_hit(avs_address, REG_ACC)) begin
			rd_val[DATA_W-1:0] = acc_q;
			rd_val[ACC_TBLH_LSB +: DATA_W] = tblh_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end else begin
			wait_q <= !((avs_read || avs_write) && wait_q);
			if (bus_rd_take) rdata_q <= rd_val;
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;
	assign irq_ack = irq_ack_q;
	assign instruction_phase = phase_q;
endmodule : mps_core
`default_nettype wire

// ==== tb/mps_core_asserts.sv ====
// mps_core_asserts: port-level checks of the sequencer core, bound into mps_core.
// assumes one clock domain and a register master that holds each request until served.
`timescale 1ns/100ps
`default_nettype none
module mps_core_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq_req,
	input wire logic irq_ack,
	input wire logic [1:0] instruction_phase
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// instruction phases
	AST_PHASE_STEP: assert property (
		instruction_phase != 2'h0 |=> instruction_phase == $past(instruction_phase) + 2'h1)
		else $error("phase did not advance by one");
	AST_RESET_STATE: assert property (
		$rose(rst_n) |-> instruction_phase == 2'h0 && avs_waitrequest && !irq_ack)
		else $error("outputs not at reset state after release");
	// ==========================================================
	// interrupt acknowledge
	AST_ACK_PULSE: assert property (
		irq_ack |=> !irq_ack [*3])
		else $error("acknowledge longer than one cycle or repeated");
	AST_ACK_PHASE: assert property (
		irq_ack |-> $past(instruction_phase) == 2'h3 || $past(instruction_phase, 2) == 2'h3)
		else $error("acknowledge not after an execute phase");
	// ==========================================================
	// register port
	AST_WAIT_ONE: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait");
	AST_WAIT_BACK: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_IDLE_WAIT: assert property (
		!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest dropped without a request");
	AST_RDATA_HOLD: assert property (
		!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	COV_ACK: cover property (irq_ack);
	COV_READ: cover property (avs_read && !avs_waitrequest);
	COV_WRITE: cover property (avs_write && !avs_waitrequest);
endmodule : mps_core_asserts
bind mps_core mps_core_asserts mps_core_asserts_inst (.clk(clk), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq_req(irq_req), .irq_ack(irq_ack),
	.instruction_phase(instruction_phase));
`default_nettype wire

// ==== tb/mps_irq_src.sv ====
// mps_irq_src: interrupt source beside the core; raises the request pin and counts acks.
// assumes the bench pulses fire for one clock per wanted interrupt.
`timescale 1ns/100ps
`default_nettype none
module mps_irq_src #(
	parameter int HOLD = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fire,
	input wire logic irq_ack,
	output logic irq_req,
	output logic [7:0] ack_count
);
	logic [3:0] hold_q;
	logic [7:0] acks_q;
	assign irq_req = hold_q != 4'h0;
	assign ack_count = acks_q;
	// held several clocks so the two-flop synchroniser cannot miss the edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 4'h0;
		end else if (fire) begin
			hold_q <= 4'(HOLD);
		end else if (hold_q != 4'h0) begin
			hold_q <= hold_q - 4'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acks_q <= 8'h0;
		end else begin
			acks_q <= acks_q + 8'(irq_ack);
		end
	end
endmodule : mps_irq_src
`default_nettype wire

// ==== tb/mps_core_tb.sv ====
// mps_core_tb: self-checking bench for the sequencer core and its register port.
// assumes the core is halted after reset and programs are loaded over the register port.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			num_errors++; \
			$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
		end \
	end
module mps_core_tb;
	import mps_pkg::*;
	typedef struct packed {
		logic [15:0] w0;
		logic [15:0] w1;
		logic [15:0] w2;
		logic [15:0] acc;
		logic [1:0] fmask;
		logic [1:0] flags;
	} mps_row_s;
	logic clk;
	logic rst_n = 1'h0;
	logic [7:0] avs_address = 8'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq_req;
	logic irq_ack;
	logic [1:0] instruction_phase;
	logic fire = 1'h0;
	logic [7:0] ack_count;
	logic [31:0] rd;
	int num_errors = 0;
	int samples_checked = 0;
	// flags field is {zero, carry}; mask picks the ones each op is known to update
	mps_row_s rows [19] = '{
		'{16'h1012, 16'h0000, 16'h2034, 16'h0046, 2'h3, 2'h0},
		'{16'h1080, 16'h0000, 16'h2080, 16'h0000, 2'h3, 2'h3},
		'{16'h1005, 16'h0000, 16'h3003, 16'h0002, 2'h3, 2'h1},
		'{16'h1003, 16'h0000, 16'h3005, 16'h00FE, 2'h3, 2'h0},
		'{16'h10F0, 16'h0000, 16'h403C, 16'h0030, 2'h2, 2'h0},
		'{16'h10F0, 16'h0000, 16'h400F, 16'h0000, 2'h2, 2'h2},
		'{16'h10F0, 16'h0000, 16'h500F, 16'h00FF, 2'h2, 2'h0},
		'{16'h105A, 16'h0000, 16'h605A, 16'h0000, 2'h2, 2'h2},
		'{16'h10FF, 16'h0000, 16'h7000, 16'h0000, 2'h2, 2'h2},
		'{16'h1000, 16'h0000, 16'h7001, 16'h00FF, 2'h2, 2'h0},
		'{16'h1081, 16'h0000, 16'h7002, 16'h0003, 2'h0, 2'h0},
		'{16'h1081, 16'h0000, 16'h7003, 16'h00C0, 2'h0, 2'h0},
		'{16'h10FF, 16'h2001, 16'h7004, 16'h0001, 2'h1, 2'h0},
		'{16'h10FF, 16'h2001, 16'h7005, 16'h0080, 2'h1, 2'h0},
		'{16'h103C, 16'h0000, 16'h7006, 16'h00C3, 2'h0, 2'h0},
		'{16'h1000, 16'hB000, 16'h1077, 16'h0000, 2'h0, 2'h0},
		'{16'h1001, 16'hB000, 16'h1077, 16'h0077, 2'h0, 2'h0},
		'{16'h1001, 16'hB001, 16'h1077, 16'h0001, 2'h0, 2'h0},
		'{16'h1002, 16'hD000, 16'hD002, 16'hD002, 2'h0, 2'h0}};
	// five nested calls overflow the four levels; interrupt entry at 0x004
	logic [10:0] pa [15] = '{11'h000, 11'h001, 11'h002, 11'h004, 11'h005, 11'h010, 11'h011,
		11'h012, 11'h020, 11'h021, 11'h030, 11'h031, 11'h040, 11'h041, 11'h050};
	logic [15:0] pw [15] = '{16'h9010, 16'h10EE, 16'h8002, 16'h1099, 16'hA001, 16'h9020,
		16'h7000, 16'h8012, 16'h9030, 16'hA000, 16'h9040, 16'hA000, 16'h9050, 16'hA000,
		16'h8050};
	logic [7:0] regs [5] = '{REG_CTRL, REG_STATUS, REG_PCL, REG_ACC, 8'h40};
	mps_core mps_core_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_req(irq_req),
		.irq_ack(irq_ack), .instruction_phase(instruction_phase));
	mps_irq_src mps_irq_src_inst (.clk(clk), .rst_n(rst_n), .fire(fire), .irq_ack(irq_ack),
		.irq_req(irq_req), .ack_count(ack_count));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// ==========================================================
	// bus and loading tasks
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// waits as long as the slave asks; only the watchdog ends a hung access
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask : bus
	task automatic load(input logic [10:0] a, input logic [15:0] w);
		bus(1'h1, REG_PM_ADDR, {21'h0, a});
		bus(1'h1, REG_PM_DATA, {16'h0, w});
	endtask : load
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		foreach (rows[i]) begin
			bus(1'h1, REG_CTRL, 32'h0);
			load(11'h0, rows[i].w0);
			load(11'h1, rows[i].w1);
			load(11'h2, rows[i].w2);
			load(11'h3, 16'h8003);
			bus(1'h1, REG_PCL, 32'h0);
			bus(1'h1, REG_CTRL, 32'h1);
			repeat (60) @(posedge clk);
			bus(1'h1, REG_CTRL, 32'h0);
			bus(1'h0, REG_ACC, 32'h0);
			`CHK(rd[15:0], rows[i].acc)
			bus(1'h0, REG_STATUS, 32'h0);
			`CHK(rd[ST_Z:ST_C] & rows[i].fmask, rows[i].flags)
		end
		load(11'h000, 16'h8105);
		load(11'h105, 16'h105A);
		load(11'h106, 16'h8106);
		bus(1'h1, REG_PCL, 32'h0);
		bus(1'h1, REG_CTRL, 32'h1);
		repeat (80) @(posedge clk);
		bus(1'h1, REG_CTRL, 32'h0);
		bus(1'h0, REG_ACC, 32'h0);
		`CHK(rd[7:0], 8'h5A)
		bus(1'h1, REG_PCL, 32'h20);
		bus(1'h0, REG_STATUS, 32'h0);
		`CHK(rd[10:0], 11'h120)
		// pc still sits in page 1 here, so page 1 jumps back to the call chain
		load(11'h100, 16'h8000);
		foreach (pa[i]) load(pa[i], pw[i]);
		bus(1'h1, REG_PCL, 32'h0);
		bus(1'h1, REG_CTRL, 32'h3);
		repeat (150) @(posedge clk);
		fire <= 1'h1;
		@(posedge clk);
		fire <= 1'h0;
		repeat (40) @(posedge clk);
		bus(1'h0, REG_STATUS, 32'h0);
		`CHK(rd[ST_FULL:ST_IRQF], 2'h3)
		`CHK(ack_count, 8'h0)
		bus(1'h1, REG_CTRL, 32'h2);
		bus(1'h1, REG_PCL, 32'h41);
		bus(1'h1, REG_CTRL, 32'h3);
		repeat (200) @(posedge clk);
		bus(1'h1, REG_CTRL, 32'h0);
		bus(1'h0, REG_ACC, 32'h0);
		`CHK(rd[7:0], 8'h9A)
		`CHK(ack_count, 8'h1)
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		bus(1'h1, 8'h40, 32'hFF);
		foreach (regs[i]) begin
			bus(1'h0, regs[i], 32'h0);
			`CHK(rd, 32'h0)
		end
		end_of_test();
	end
endmodule : mps_core_tb
`default_nettype wire
